// ### core/fmc_consts.vh
// Constants for the flash mode control block
`ifndef FMC_CONSTS_VH
`define FMC_CONSTS_VH

// Register map, byte addresses
`define FMC_ADDR_W 4
`define FMC_OFS_MODE 4'h0
`define FMC_OFS_EBLO 4'h4
`define FMC_OFS_EBHI 4'h8
`define FMC_OFS_STAT 4'hc

// Mode control field positions
`define FMC_BIT_WEG 6
`define FMC_BIT_ESU 5
`define FMC_BIT_PSU 4
`define FMC_BIT_EV 3
`define FMC_BIT_PV 2
`define FMC_BIT_ERS 1
`define FMC_BIT_PRG 0
`define FMC_MODE_RST 8'h00
`define FMC_MODE_WMASK 8'h7f

// Array geometry
`define FMC_ARRAY_AW 17
`define FMC_NBLK 10
`define FMC_UNIT_LSB 7

// Erase block base addresses
`define FMC_EB0_BASE 17'h00000
`define FMC_EB1_BASE 17'h00400
`define FMC_EB2_BASE 17'h00800
`define FMC_EB3_BASE 17'h00c00
`define FMC_EB4_BASE 17'h01000
`define FMC_EB5_BASE 17'h08000
`define FMC_EB6_BASE 17'h0c000
`define FMC_EB7_BASE 17'h0e000
`define FMC_EB8_BASE 17'h10000
`define FMC_EB9_BASE 17'h18000
`define FMC_ARRAY_END 18'h20000

`endif

// ### core/fmc_blk_decode.v
// Maps an array address to its erase block number
`include "fmc_consts.vh"
module fmc_blk_decode (
    input wire [`FMC_ARRAY_AW-1:0] addr,
    output reg [3:0] blk
);
    // Ascending block bounds
    always @* begin
        if (addr < `FMC_EB1_BASE) blk = 4'h0;
        else if (addr < `FMC_EB2_BASE) blk = 4'h1;
        else if (addr < `FMC_EB3_BASE) blk = 4'h2;
        else if (addr < `FMC_EB4_BASE) blk = 4'h3;
        else if (addr < `FMC_EB5_BASE) blk = 4'h4;
        else if (addr < `FMC_EB6_BASE) blk = 4'h5;
        else if (addr < `FMC_EB7_BASE) blk = 4'h6;
        else if (addr < `FMC_EB8_BASE) blk = 4'h7;
        else if (addr < `FMC_EB9_BASE) blk = 4'h8;
        else blk = 4'h9;
    end
endmodule // fmc_blk_decode

// ### core/fmc_unit_check.v
// Checks a programming start address for unit alignment
`include "fmc_consts.vh"
module fmc_unit_check (
    input wire [`FMC_ARRAY_AW-1:0] addr,
    output wire aligned
);
    // Low seven bits zero means low byte is 00 or 80
    assign aligned = ~|addr[`FMC_UNIT_LSB-1:0];
endmodule // fmc_unit_check

// ### core/fmc_mode_ctrl.v
// Flash program/erase mode control register and state outputs
//
// The implementer's own choices: the address map and strobed register access.
`include "fmc_consts.vh"
module fmc_mode_ctrl (
    clk_sys,
    sys_rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    prog_addr,
    prog_addr_ok,
    prog_blk,
    erase_blk_sel,
    erase_blk_valid,
    erase_setup_bit,
    program_setup_bit,
    erase_verify_mode,
    program_verify_mode,
    erase_active,
    program_active
);
    input wire clk_sys;
    input wire sys_rst;
    input wire [`FMC_ADDR_W-1:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire [`FMC_ARRAY_AW-1:0] prog_addr;
    output wire prog_addr_ok;
    output wire [3:0] prog_blk;
    output wire [`FMC_NBLK-1:0] erase_blk_sel;
    output wire erase_blk_valid;
    output wire erase_setup_bit;
    output wire program_setup_bit;
    output wire erase_verify_mode;
    output wire program_verify_mode;
    output wire erase_active;
    output wire program_active;

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [6:0] mode_q;
    reg [6:0] mode_d;
    reg [7:0] eblo_q;
    reg [7:0] eblo_d;
    reg [1:0] ebhi_q;
    reg [1:0] ebhi_d;
    wire write_enable_gate;
    wire wr_mode;
    wire wr_eblo;
    wire wr_ebhi;
    wire [7:0] wmask;
    wire [`FMC_NBLK-1:0] sel_all;
    wire one_hot;
    integer i;
    reg [3:0] nset;

    assign write_enable_gate = mode_q[`FMC_BIT_WEG];
    assign wr_mode = reg_wr && (reg_addr == `FMC_OFS_MODE);
    assign wr_eblo = reg_wr && (reg_addr == `FMC_OFS_EBLO);
    assign wr_ebhi = reg_wr && (reg_addr == `FMC_OFS_EBHI);
    assign wmask = `FMC_MODE_WMASK;

    ////////////////////////////////////////////////////////////////////
    // Mode control next value
    always @* begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = reg_wdata[6:0] & wmask[6:0];
            // Enable is judged on the new value so clearing it drops all
            if (!reg_wdata[`FMC_BIT_WEG]) begin
                mode_d = 7'h00;
            end else if (!mode_q[`FMC_BIT_WEG]) begin
                mode_d = 7'h40;
            end else begin
                // Trigger only accepted with its setup already held
                if (!mode_q[`FMC_BIT_ESU] || !reg_wdata[`FMC_BIT_ESU]) begin
                    mode_d[`FMC_BIT_ERS] = mode_q[`FMC_BIT_ERS] &
                        reg_wdata[`FMC_BIT_ERS] &
                        reg_wdata[`FMC_BIT_ESU];
                end
                if (!mode_q[`FMC_BIT_PSU] || !reg_wdata[`FMC_BIT_PSU]) begin
                    mode_d[`FMC_BIT_PRG] = mode_q[`FMC_BIT_PRG] &
                        reg_wdata[`FMC_BIT_PRG] &
                        reg_wdata[`FMC_BIT_PSU];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Erase block select next values
    always @* begin
        eblo_d = eblo_q;
        ebhi_d = ebhi_q;
        if (wr_eblo) begin
            eblo_d = reg_wdata;
        end
        if (wr_ebhi) begin
            ebhi_d = reg_wdata[1:0];
        end
        // Selects held clear while writes are disabled
        if (!mode_d[`FMC_BIT_WEG]) begin
            eblo_d = 8'h00;
            ebhi_d = 2'h0;
        end
        nset = 4'h0;
        for (i = 0; i < 8; i = i + 1) begin
            nset = nset + {3'h0, eblo_d[i]};
        end
        nset = nset + {3'h0, ebhi_d[0]} + {3'h0, ebhi_d[1]};
        // More than one block selected clears them all
        if (nset > 4'h1) begin
            eblo_d = 8'h00;
            ebhi_d = 2'h0;
        end
    end

    // State update; no timer ends any mode
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_q <= 7'h00;
            eblo_q <= 8'h00;
            ebhi_q <= 2'h0;
        end else begin
            mode_q <= mode_d;
            eblo_q <= eblo_d;
            ebhi_q <= ebhi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port, one cycle latency
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `FMC_OFS_MODE: reg_rdata <= {1'b0, mode_q};
                `FMC_OFS_EBLO: reg_rdata <= eblo_q;
                `FMC_OFS_EBHI: reg_rdata <= {6'h00, ebhi_q};
                `FMC_OFS_STAT: reg_rdata <= {4'h0, erase_active,
                    program_active, erase_blk_valid, prog_addr_ok};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode outputs
    assign erase_setup_bit = mode_q[`FMC_BIT_ESU];
    assign program_setup_bit = mode_q[`FMC_BIT_PSU];
    assign erase_verify_mode = mode_q[`FMC_BIT_EV];
    assign program_verify_mode = mode_q[`FMC_BIT_PV];
    assign erase_active = mode_q[`FMC_BIT_ERS] & write_enable_gate &
        mode_q[`FMC_BIT_ESU];
    assign program_active = mode_q[`FMC_BIT_PRG] & write_enable_gate &
        mode_q[`FMC_BIT_PSU];

    // Block selection and geometry helpers
    assign sel_all = {ebhi_q, eblo_q};
    assign erase_blk_sel = sel_all;
    assign one_hot = (sel_all != 10'h000);
    assign erase_blk_valid = one_hot;

    fmc_unit_check u_unit (
        .addr(prog_addr),
        .aligned(prog_addr_ok)
    );

    fmc_blk_decode u_blk (
        .addr(prog_addr),
        .blk(prog_blk)
    );
endmodule // fmc_mode_ctrl

// ### verification/fmc_mode_chk_assertions.sv
// Assertions on the mode control block ports
`include "fmc_consts.vh"
module fmc_mode_chk (
    input wire clk_sys,
    input wire sys_rst,
    input wire [`FMC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [`FMC_ARRAY_AW-1:0] prog_addr,
    input wire prog_addr_ok,
    input wire [`FMC_NBLK-1:0] erase_blk_sel,
    input wire erase_blk_valid,
    input wire erase_setup_bit,
    input wire program_setup_bit,
    input wire erase_active,
    input wire program_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Mode writes with the gate bit high or low
    sequence wr_on;
        reg_wr && reg_addr == `FMC_OFS_MODE && reg_wdata[6];
    endsequence
    sequence wr_off;
        reg_wr && reg_addr == `FMC_OFS_MODE && !reg_wdata[6];
    endsequence
    rsvd_bit_a: assert property (reg_rd |=> !reg_rdata[7])
        else $error("bit 7 read as one");
    gate_off_a: assert property (wr_off |=> !(erase_setup_bit ||
        program_setup_bit) && erase_blk_sel == 10'h000)
        else $error("gate off left bits set");
    esu_follow_a: assert property (erase_setup_bit ##0 wr_on
        |=> erase_setup_bit == $past(reg_wdata[5]))
        else $error("erase setup not written");
    psu_follow_a: assert property (program_setup_bit ##0 wr_on
        |=> program_setup_bit == $past(reg_wdata[4]))
        else $error("program setup not written");
    erase_start_a: assert property ($rose(erase_active) |->
        $past(erase_setup_bit && reg_wr && reg_wdata[1]))
        else $error("erase began without setup");
    prog_start_a: assert property ($rose(program_active) |->
        $past(program_setup_bit && reg_wr && reg_wdata[0]))
        else $error("program began without setup");
    mode_hold_a: assert property (!reg_wr |=> $stable({erase_active,
        program_active, erase_setup_bit, program_setup_bit}))
        else $error("mode changed without a write");
    unit_align_a: assert property (prog_addr_ok ==
        (prog_addr[6:0] == 7'h00))
        else $error("unit alignment wrong");
    blk_onehot_a: assert property ($onehot0(erase_blk_sel) &&
        erase_blk_valid == $onehot(erase_blk_sel))
        else $error("block select not one-hot");
endmodule // fmc_mode_chk
////////////////////////////////////////
bind fmc_mode_ctrl fmc_mode_chk fmc_mode_chk_i (.clk_sys, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prog_addr,
    .prog_addr_ok, .erase_blk_sel, .erase_blk_valid, .erase_setup_bit,
    .program_setup_bit, .erase_active, .program_active);

// ### verification/tb.sv
// Random register traffic checked against a reference model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 0, prog_blk;
    logic [7:0] reg_wdata = 0, reg_rdata, m = 0, x = 0;
    logic [16:0] prog_addr = 0, a;
    logic [9:0] erase_blk_sel, eb = 0;
    logic prog_addr_ok, erase_blk_valid, erase_setup_bit, erase_active;
    logic program_setup_bit, erase_verify_mode, program_verify_mode;
    logic program_active;
    integer err_total = 0, checks = 0, i, b;
    fmc_mode_ctrl fmc_mode_ctrl_i (.clk_sys, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prog_addr, .prog_addr_ok,
        .prog_blk, .erase_blk_sel, .erase_blk_valid, .erase_setup_bit,
        .program_setup_bit, .erase_verify_mode, .program_verify_mode,
        .erase_active, .program_active);
    initial forever #2 clk_sys = ~clk_sys;
    ////////////////////////////////////////
    // Reference register model, stepped at each rising edge
    always @(posedge clk_sys) begin
        x = 8'h00;
        if (sys_rst) begin
            m = 8'h00;
            eb = 10'h000;
        end else if (reg_rd) begin
            case (reg_addr)
            4'h0: x = m;
            4'h4: x = eb[7:0];
            4'h8: x = {6'h00, eb[9:8]};
            4'hc: x = {4'h0, m[1:0], |eb, prog_addr[6:0] == 7'h00};
            endcase
        end else if (reg_wr) begin
            if (reg_addr == 4'h0 && m[6] && reg_wdata[6])
                m = {1'b0, reg_wdata[6:2], reg_wdata[1] & m[5] & reg_wdata[5],
                    reg_wdata[0] & m[4] & reg_wdata[4]};
            else if (reg_addr == 4'h0)
                m = reg_wdata[6] ? 8'h40 : 8'h00;
            if (!m[6])
                eb = 10'h000;
            else if (reg_addr == 4'h4)
                eb[7:0] = reg_wdata;
            else if (reg_addr == 4'h8)
                eb[9:8] = reg_wdata[1:0];
            if (!$onehot0(eb))
                eb = 10'h000;
        end
    end
    // Compare one result with its expectation
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // Mid-cycle comparison of all outputs
    always @(negedge clk_sys) begin
        a = prog_addr;
        b = a < 'h1000 ? a >> 10 : a < 'h8000 ? 4 : a < 'hc000 ? 5 :
            a < 'he000 ? 6 : a < 'h10000 ? 7 : a < 'h18000 ? 8 : 9;
        if (!sys_rst) begin
            chk(reg_rdata, x);
            chk({erase_setup_bit, program_setup_bit, erase_verify_mode,
                program_verify_mode, erase_active, program_active},
                m[5:0]);
            chk({erase_blk_sel, erase_blk_valid}, {eb, |eb});
            chk({prog_blk, prog_addr_ok}, {b[3:0], a[6:0] == 0});
        end
    end
    // Report counts and end the run
    task complete_run;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Random strobes, data and array addresses, reset midway
    initial begin
        i = $urandom(32'h89ebe720);
        repeat (3) @(posedge clk_sys);
        sys_rst <= 0;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk_sys);
            b = $urandom;
            reg_wr <= b[0];
            reg_rd <= !b[0] && b[1];
            reg_addr <= b[3] ? {b[5:4], 2'b00} : b[7:4];
            reg_wdata <= b[15:8] | (b[18:16] != 0 ? 8'h40 : 8'h00);
            prog_addr <= b[19] ? {b[31:22], 7'h00} : b[31:15];
            sys_rst <= i == 1500;
        end
        complete_run;
    end
endmodule // tb
